/* File: common/lbu_aux_if.sv */
// Links the core to its block stack and edge history memory
// Assumes all three parties run on core_clk
`timescale 1ns/10ps
interface lbu_aux_if;
   import lbu_pkg::*;
   logic              push;
   logic              pop;
   logic              flush;
   logic              push_bit;
   logic              top_bit;
   logic              empty;
   logic              full;
   logic [SLOT_W-1:0] slot;
   logic              ed_wr;
   logic              ed_bit;
   logic              ed_prev;
   modport core (output push, pop, flush, push_bit, slot, ed_wr, ed_bit,
                 input top_bit, empty, full, ed_prev);
   modport stk  (input push, pop, flush, push_bit, output top_bit, empty, full);
   modport edg  (input slot, ed_wr, ed_bit, output ed_prev);
endinterface : lbu_aux_if

/* File: common/lbu_pkg.sv */
// Constants, instruction layout and helpers of the ladder boolean unit
// Assumes a 32-bit program word and a one-bit relay image port
package lbu_pkg;
   localparam int WORD_W     = 32;
   localparam int OP_W       = 5;
   localparam int AREA_W     = 3;
   localparam int NUM_W      = 16;
   localparam int SLOT_W     = 6;
   localparam int EDGE_SLOTS = 64;
   localparam int STK_DEPTH  = 8;
   localparam int STK_CNT_W  = 4;
   localparam int STK_IDX_W  = 3;
   // Field positions in the first program word
   localparam int OP_LSB     = 27;
   localparam int AREA_LSB   = 24;
   localparam int IDX_BIT    = 23;

   typedef logic [OP_W-1:0]   lbu_op_t;
   typedef logic [AREA_W-1:0] lbu_area_t;

   localparam lbu_op_t OP_NOP = 5'h00, OP_LOAD_OPEN = 5'h01, OP_LOAD_CLOSED = 5'h02;
   localparam lbu_op_t OP_WRITE = 5'h03, OP_INVERT = 5'h04, OP_SERIES_OPEN = 5'h05;
   localparam lbu_op_t OP_SERIES_CLOSED = 5'h06, OP_PAR_OPEN = 5'h07, OP_PAR_CLOSED = 5'h08;
   localparam lbu_op_t OP_RISE_LOAD = 5'h09, OP_FALL_LOAD = 5'h0a, OP_RISE_SERIES = 5'h0b;
   localparam lbu_op_t OP_FALL_SERIES = 5'h0c, OP_RISE_PAR = 5'h0d, OP_FALL_PAR = 5'h0e;
   localparam lbu_op_t OP_RISE_PULSE = 5'h0f, OP_FALL_PULSE = 5'h10, OP_TOGGLE = 5'h11;
   localparam lbu_op_t OP_BLOCK_SERIES = 5'h12, OP_BLOCK_PAR = 5'h13;

   // Relay areas: input, output, internal, timer, counter, link, pulse, extra
   localparam lbu_area_t AREA_X = 3'h0, AREA_Y = 3'h1, AREA_R = 3'h2, AREA_T = 3'h3;
   localparam lbu_area_t AREA_C = 3'h4, AREA_L = 3'h5, AREA_P = 3'h6, AREA_E = 3'h7;

   // Short-form limits: 1280, 1120, 256; no limit for pulse and extra relays
   localparam logic [NUM_W-1:0] LIM_IO = 16'h0500, LIM_INT = 16'h0460;
   localparam logic [NUM_W-1:0] LIM_TC = 16'h0100, LIM_NONE = 16'hffff;

   localparam logic [STK_CNT_W-1:0] STK_FULL = 4'h8;
   localparam logic RST_READY  = 1'b1;
   localparam logic RST_RESULT = 1'b0;

   typedef enum logic [1:0] {ST_FETCH, ST_MORE, ST_READ, ST_EXEC} lbu_state_e;

   function automatic logic [NUM_W-1:0] ext_limit(input lbu_area_t a);
      if (a == AREA_R) return LIM_INT;
      else if (a == AREA_T || a == AREA_C) return LIM_TC;
      else if (a == AREA_P || a == AREA_E) return LIM_NONE;
      else return LIM_IO;
   endfunction : ext_limit

   function automatic logic is_basic(input lbu_op_t o);
      return o inside {OP_LOAD_OPEN, OP_LOAD_CLOSED, OP_WRITE, OP_SERIES_OPEN,
                       OP_SERIES_CLOSED, OP_PAR_OPEN, OP_PAR_CLOSED};
   endfunction : is_basic

   function automatic logic [1:0] extra_words(input lbu_op_t o);
      if (o == OP_TOGGLE) return 2'h2;
      else if (o >= OP_RISE_LOAD && o <= OP_FALL_PULSE) return 2'h1;
      else return 2'h0;
   endfunction : extra_words

   function automatic logic reads_img(input lbu_op_t o);
      return is_basic(o) && o != OP_WRITE || (o >= OP_RISE_LOAD && o <= OP_FALL_PAR) || o == OP_TOGGLE;
   endfunction : reads_img

   function automatic logic out_ok(input lbu_area_t a);
      return a == AREA_Y || a == AREA_R || a == AREA_L || a == AREA_E;
   endfunction : out_ok

   function automatic logic edge_term(input logic cur, input logic prev, input logic fall);
      return fall ? (!cur && prev) : (cur && !prev);
   endfunction : edge_term
endpackage : lbu_pkg

/* File: rtl/lbu_block_stack.sv */
// Stack of pending chain results for block combination
// Assumes flush arrives only at the end of a scan
`timescale 1ns/10ps
module lbu_block_stack (
   input wire logic core_clk,
   input wire logic sys_rst,
   lbu_aux_if.stk   stk
);
   import lbu_pkg::*;
   logic                 mem_ff  [STK_DEPTH];
   logic                 nxt_mem [STK_DEPTH];
   logic [STK_CNT_W-1:0] cnt_ff;
   logic [STK_CNT_W-1:0] nxt_cnt;
   logic [STK_IDX_W-1:0] top_idx;

   assign stk.empty = (cnt_ff == '0);
   assign stk.full  = (cnt_ff == STK_FULL);
   assign top_idx   = cnt_ff[STK_IDX_W-1:0] - 3'h1;
   assign stk.top_bit = stk.empty ? 1'b0 : mem_ff[top_idx];

   // Flush wins; a push when full or pop when empty is dropped
   always_comb begin
      nxt_mem = mem_ff;
      nxt_cnt = cnt_ff;
      if (stk.flush) begin
         nxt_cnt = '0;
      end else if (stk.push && !stk.full) begin
         nxt_mem[cnt_ff[STK_IDX_W-1:0]] = stk.push_bit;
         nxt_cnt = cnt_ff + 4'h1;
      end else if (stk.pop && !stk.empty) begin
         nxt_cnt = cnt_ff - 4'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_ff <= '0;
         for (int i = 0; i < STK_DEPTH; i++) begin
            mem_ff[i] <= 1'b0;
         end
      end else begin
         cnt_ff <= nxt_cnt;
         mem_ff <= nxt_mem;
      end
   end

   property p_push_top;
      @(posedge core_clk) disable iff (sys_rst)
      stk.push && !stk.full && !stk.flush |=> stk.top_bit == $past(stk.push_bit) && !stk.empty;
   endproperty
   a_push_top: assert property (p_push_top) else $error("pushed result not on top");

   property p_pop_cnt;
      @(posedge core_clk) disable iff (sys_rst)
      stk.pop && !stk.empty && !stk.flush && !stk.push |=> cnt_ff == $past(cnt_ff) - 4'h1;
   endproperty
   a_pop_cnt: assert property (p_pop_cnt) else $error("pop did not drop one block");
endmodule : lbu_block_stack

/* File: rtl/lbu_edge_mem.sv */
// Previous-scan samples of every edge instruction instance
// Assumes the core writes a slot once per execution of its instruction
`timescale 1ns/10ps
module lbu_edge_mem (
   input wire logic core_clk,
   input wire logic sys_rst,
   lbu_aux_if.edg   edg
);
   import lbu_pkg::*;
   logic prev_ff  [EDGE_SLOTS];
   logic nxt_prev [EDGE_SLOTS];

   // Read is combinational so the core sees last scan's sample
   assign edg.ed_prev = prev_ff[edg.slot];

   // Store this scan's sample for the next comparison
   always_comb begin
      nxt_prev = prev_ff;
      if (edg.ed_wr) begin
         nxt_prev[edg.slot] = edg.ed_bit;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < EDGE_SLOTS; i++) begin
            prev_ff[i] <= 1'b0;
         end
      end else begin
         prev_ff <= nxt_prev;
      end
   end

   property p_edge_hold;
      @(posedge core_clk) disable iff (sys_rst)
      edg.ed_wr ##1 (edg.slot == $past(edg.slot)) |-> edg.ed_prev == $past(edg.ed_bit);
   endproperty
   a_edge_hold: assert property (p_edge_hold) else $error("edge sample not kept");
endmodule : lbu_edge_mem

/* File: rtl/lbu_top.sv */
// Bit-logic execution core of the ladder boolean unit
// Assumes program words arrive on a valid/ready port and the relay
// image answers a read one cycle after the request
`timescale 1ns/10ps
module lbu_top (
   input  wire logic                        core_clk,
   input  wire logic                        sys_rst,
   input  wire logic                        instr_valid,
   input  wire logic [lbu_pkg::WORD_W-1:0]  instr_word,
   output logic                             instr_ready,
   input  wire logic                        scan_end,
   output logic                             img_rd_req,
   output lbu_pkg::lbu_area_t               img_area,
   output logic [lbu_pkg::NUM_W-1:0]        img_addr,
   input  wire logic                        img_rd_data,
   output logic                             img_wr_en,
   output logic                             img_wr_data,
   output logic                             result,
   output logic                             op_err
);
   import lbu_pkg::*;

   lbu_state_e        state_ff, nxt_state;
   lbu_op_t           op_ff, nxt_op;
   lbu_area_t         area_ff, nxt_area;
   logic [NUM_W-1:0]  addr_ff, nxt_addr;
   logic [1:0]        left_ff, nxt_left;
   logic [SLOT_W-1:0] slot_ff, nxt_slot;
   logic              res_ff, nxt_res;
   logic              pend_ff, nxt_pend;
   logic              rdy_ff, nxt_rdy;
   logic              rd_req_ff, nxt_rd_req;
   logic              wr_en_ff, nxt_wr_en;
   logic              wr_data_ff, nxt_wr_data;
   logic              err_ff, nxt_err;
   lbu_op_t           w_op;
   lbu_area_t         w_area;
   logic [NUM_W-1:0]  w_num;
   logic              w_long;
   logic              take;
   logic              fin;
   logic              ld;
   logic              ld_val;
   logic              v;
   logic              prev;

   lbu_aux_if aux ();

   lbu_block_stack u_stack (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .stk      (aux.stk)
   );

   lbu_edge_mem u_edge (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .edg      (aux.edg)
   );

   // Outputs straight from flops
   assign instr_ready = rdy_ff;
   assign img_rd_req  = rd_req_ff;
   assign img_area    = area_ff;
   assign img_addr    = addr_ff;
   assign img_wr_en   = wr_en_ff;
   assign img_wr_data = wr_data_ff;
   assign result      = res_ff;
   assign op_err      = err_ff;
   assign aux.slot    = slot_ff;

   // First-word fields
   assign w_op   = instr_word[OP_LSB +: OP_W];
   assign w_area = instr_word[AREA_LSB +: AREA_W];
   assign w_num  = instr_word[NUM_W-1:0];
   assign w_long = is_basic(w_op) && (instr_word[IDX_BIT] || w_num >= ext_limit(w_area));
   assign take   = instr_valid && rdy_ff;

   // Decode, fetch of extra steps and execution
   always_comb begin
      nxt_state   = state_ff;
      nxt_op      = op_ff;
      nxt_area    = area_ff;
      nxt_addr    = addr_ff;
      nxt_left    = left_ff;
      nxt_slot    = slot_ff;
      nxt_res     = res_ff;
      nxt_pend    = pend_ff;
      nxt_rdy     = rdy_ff;
      nxt_rd_req  = 1'b0;
      nxt_wr_en   = 1'b0;
      nxt_wr_data = wr_data_ff;
      nxt_err     = 1'b0;
      aux.push     = 1'b0;
      aux.pop      = 1'b0;
      aux.flush    = scan_end;
      aux.push_bit = res_ff;
      aux.ed_wr    = 1'b0;
      aux.ed_bit   = 1'b0;
      fin    = 1'b0;
      ld     = 1'b0;
      ld_val = 1'b0;
      v      = img_rd_data;
      prev   = aux.ed_prev;
      case (state_ff)
         ST_FETCH: begin
            if (take) begin
               nxt_op   = w_op;
               nxt_area = w_area;
               nxt_addr = w_num;
               nxt_left = w_long ? 2'h1 : extra_words(w_op);
               fin      = (nxt_left == 2'h0);
               if (!fin) begin
                  nxt_state = ST_MORE;
               end
            end
         end
         ST_MORE: begin
            if (take) begin
               nxt_left = left_ff - 2'h1;
               // Operand or slot sits in the last extra word
               if (left_ff == 2'h1) begin
                  fin = 1'b1;
                  if (is_basic(op_ff)) begin
                     nxt_addr = instr_word[NUM_W-1:0];
                  end else begin
                     nxt_slot = instr_word[SLOT_W-1:0];
                  end
               end
            end
         end
         ST_READ: begin
            nxt_state = ST_EXEC;
         end
         ST_EXEC: begin
            nxt_state = ST_FETCH;
            nxt_rdy   = 1'b1;
            // Contacts from any of the eight areas are accepted
            case (op_ff)
               OP_NOP: begin
               end
               OP_LOAD_OPEN: begin
                  ld     = 1'b1;
                  ld_val = v;
               end
               OP_LOAD_CLOSED: begin
                  ld     = 1'b1;
                  ld_val = !v;
               end
               OP_WRITE: begin
                  if (out_ok(area_ff)) begin
                     nxt_wr_en   = 1'b1;
                     nxt_wr_data = res_ff;
                     nxt_pend    = 1'b0;
                  end else begin
                     nxt_err = 1'b1;
                  end
               end
               OP_INVERT: nxt_res = !res_ff;
               OP_SERIES_OPEN: nxt_res = res_ff && v;
               OP_SERIES_CLOSED: nxt_res = res_ff && !v;
               OP_PAR_OPEN: nxt_res = res_ff || v;
               OP_PAR_CLOSED: nxt_res = res_ff || !v;
               OP_RISE_LOAD, OP_FALL_LOAD: begin
                  ld         = 1'b1;
                  ld_val     = edge_term(v, prev, op_ff == OP_FALL_LOAD);
                  aux.ed_wr  = 1'b1;
                  aux.ed_bit = v;
               end
               OP_RISE_SERIES, OP_FALL_SERIES: begin
                  nxt_res    = res_ff && edge_term(v, prev, op_ff == OP_FALL_SERIES);
                  aux.ed_wr  = 1'b1;
                  aux.ed_bit = v;
               end
               OP_RISE_PAR, OP_FALL_PAR: begin
                  nxt_res    = res_ff || edge_term(v, prev, op_ff == OP_FALL_PAR);
                  aux.ed_wr  = 1'b1;
                  aux.ed_bit = v;
               end
               OP_RISE_PULSE, OP_FALL_PULSE: begin
                  aux.ed_wr  = 1'b1;
                  aux.ed_bit = res_ff;
                  // Written every scan so the relay drops after one scan
                  if (area_ff == AREA_P) begin
                     nxt_wr_en   = 1'b1;
                     nxt_wr_data = edge_term(res_ff, prev, op_ff == OP_FALL_PULSE);
                  end else begin
                     nxt_err = 1'b1;
                  end
               end
               OP_TOGGLE: begin
                  aux.ed_wr  = 1'b1;
                  aux.ed_bit = res_ff;
                  if (!out_ok(area_ff)) begin
                     nxt_err = 1'b1;
                  end else if (edge_term(res_ff, prev, 1'b0)) begin
                     nxt_wr_en   = 1'b1;
                     nxt_wr_data = !v;
                  end
               end
               OP_BLOCK_SERIES, OP_BLOCK_PAR: begin
                  if (aux.empty) begin
                     nxt_err = 1'b1;
                  end else begin
                     aux.pop = 1'b1;
                     if (op_ff == OP_BLOCK_SERIES) begin
                        nxt_res = aux.top_bit && res_ff;
                     end else begin
                        nxt_res = aux.top_bit || res_ff;
                     end
                  end
               end
               default: nxt_err = 1'b1;
            endcase
         end
         default: nxt_state = ST_FETCH;
      endcase
      // All steps in: read the operand or execute at once
      if (fin) begin
         nxt_rdy = 1'b0;
         if (reads_img(nxt_op)) begin
            nxt_rd_req = 1'b1;
            nxt_state  = ST_READ;
         end else begin
            nxt_state = ST_EXEC;
         end
      end
      // Scan end closes the chain; a load in the same cycle still opens one
      if (scan_end) begin
         nxt_pend = 1'b0;
      end
      if (ld) begin
         if (pend_ff) begin
            if (aux.full) begin
               nxt_err = 1'b1;
            end else begin
               aux.push = 1'b1;
            end
         end
         nxt_res  = ld_val;
         nxt_pend = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_ff   <= ST_FETCH;
         op_ff      <= OP_NOP;
         area_ff    <= AREA_X;
         addr_ff    <= '0;
         left_ff    <= 2'h0;
         slot_ff    <= '0;
         res_ff     <= RST_RESULT;
         pend_ff    <= 1'b0;
         rdy_ff     <= RST_READY;
         rd_req_ff  <= 1'b0;
         wr_en_ff   <= 1'b0;
         wr_data_ff <= 1'b0;
         err_ff     <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         op_ff      <= nxt_op;
         area_ff    <= nxt_area;
         addr_ff    <= nxt_addr;
         left_ff    <= nxt_left;
         slot_ff    <= nxt_slot;
         res_ff     <= nxt_res;
         pend_ff    <= nxt_pend;
         rdy_ff     <= nxt_rdy;
         rd_req_ff  <= nxt_rd_req;
         wr_en_ff   <= nxt_wr_en;
         wr_data_ff <= nxt_wr_data;
         err_ff     <= nxt_err;
      end
   end

   // Checks on execution results
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_exec(lbu_op_t o);
      state_ff == ST_EXEC && op_ff == o;
   endsequence

   sequence s_read_then_exec;
      rd_req_ff ##1 (state_ff == ST_EXEC);
   endsequence

   property p_ld_open;
      s_exec(OP_LOAD_OPEN) |=> res_ff == $past(img_rd_data) && pend_ff;
   endproperty
   a_ld_open: assert property (p_ld_open) else $error("load-open result wrong");

   property p_ld_closed;
      s_exec(OP_LOAD_CLOSED) |=> res_ff == !$past(img_rd_data);
   endproperty
   a_ld_closed: assert property (p_ld_closed) else $error("load-closed result wrong");

   property p_write;
      s_exec(OP_WRITE) ##0 out_ok(area_ff) |=> img_wr_en && img_wr_data == $past(res_ff);
   endproperty
   a_write: assert property (p_write) else $error("output write missing");

   property p_write_bad;
      s_exec(OP_WRITE) ##0 !out_ok(area_ff) |=> !img_wr_en && op_err;
   endproperty
   a_write_bad: assert property (p_write_bad) else $error("illegal output target written");

   property p_invert;
      s_exec(OP_INVERT) |=> res_ff != $past(res_ff);
   endproperty
   a_invert: assert property (p_invert) else $error("invert failed");

   property p_ser_open;
      s_exec(OP_SERIES_OPEN) |=> res_ff == ($past(res_ff) && $past(img_rd_data));
   endproperty
   a_ser_open: assert property (p_ser_open) else $error("series-open wrong");

   property p_par_closed;
      s_exec(OP_PAR_CLOSED) |=> res_ff == ($past(res_ff) || !$past(img_rd_data));
   endproperty
   a_par_closed: assert property (p_par_closed) else $error("parallel-closed wrong");

   property p_rise_load;
      s_exec(OP_RISE_LOAD) |=> res_ff == ($past(img_rd_data) && !$past(aux.ed_prev));
   endproperty
   a_rise_load: assert property (p_rise_load) else $error("rising load wrong");

   property p_pulse;
      s_exec(OP_RISE_PULSE) ##0 area_ff == AREA_P
         |=> img_wr_en && img_wr_data == ($past(res_ff) && !$past(aux.ed_prev));
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse relay wrong");

   property p_block_series;
      s_exec(OP_BLOCK_SERIES) ##0 !aux.empty |=> res_ff == ($past(aux.top_bit) && $past(res_ff));
   endproperty
   a_block_series: assert property (p_block_series) else $error("block series wrong");

   property p_long;
      state_ff == ST_FETCH && take && w_long |=> state_ff == ST_MORE ##0 rdy_ff;
   endproperty
   a_long: assert property (p_long) else $error("long form not fetched");

   property p_read;
      state_ff == ST_FETCH && take && reads_img(w_op) && extra_words(w_op) == 2'h0 && !w_long
         |=> s_read_then_exec;
   endproperty
   a_read: assert property (p_read) else $error("operand read sequence broken");
endmodule : lbu_top

/* File: sim/ladder_boolean_unit_tb_top.sv */
// Self-checking bench of lbu_top with the relay image model
// Assumes 40 MHz core_clk and inputs driven at falling edges
`timescale 1ns/10ps
module ladder_boolean_unit_tb_top;
   import lbu_pkg::*;
   logic              core_clk, sys_rst, instr_valid, instr_ready, scan_end;
   logic [WORD_W-1:0] instr_word;
   logic              img_rd_req, img_rd_data, img_wr_en, img_wr_data, result, op_err;
   lbu_area_t         img_area;
   logic [NUM_W-1:0]  img_addr;
   int                miscompares, samples_checked, cyc, err_cnt;

   lbu_top DUT (.core_clk(core_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
      .instr_word(instr_word), .instr_ready(instr_ready), .scan_end(scan_end),
      .img_rd_req(img_rd_req), .img_area(img_area), .img_addr(img_addr),
      .img_rd_data(img_rd_data), .img_wr_en(img_wr_en), .img_wr_data(img_wr_data),
      .result(result), .op_err(op_err));
   lbu_img_model img (.core_clk(core_clk), .img_rd_req(img_rd_req), .img_area(img_area),
      .img_addr(img_addr), .img_rd_data(img_rd_data), .img_wr_en(img_wr_en),
      .img_wr_data(img_wr_data));

   // 25 ns period
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic end_of_test();
      if (miscompares == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test

   // Hang guard, far above the few hundred cycles needed; handshake waits rely on it
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         end_of_test();
      end
   end

   // Error flag stands one cycle only, so count its pulses
   always @(posedge core_clk) begin
      if (op_err === 1'b1) err_cnt++;
   end

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   function automatic logic [WORD_W-1:0] w(lbu_op_t o, lbu_area_t a, logic [NUM_W-1:0] n);
      return {o, a, 8'h00, n};
   endfunction : w

   // Hold one word until taken on a ready edge
   task automatic sw(input logic [WORD_W-1:0] d);
      @(negedge core_clk);
      instr_valid = 1'b1;
      instr_word = d;
      do begin @(posedge core_clk); end while (instr_ready !== 1'b1);
   endtask : sw

   // Whole instruction, then wait for ready back plus a write landing
   task automatic ex(input lbu_op_t o, lbu_area_t a, logic [NUM_W-1:0] n, int nx, logic [NUM_W-1:0] xw);
      int k;
      sw(w(o, a, n));
      for (k = 0; k < nx; k++) sw({16'h0000, xw});
      @(negedge core_clk);
      instr_valid = 1'b0;
      do begin @(posedge core_clk); end while (instr_ready !== 1'b1);
      @(negedge core_clk);
      @(negedge core_clk);
   endtask : ex

   task automatic scan();
      @(negedge core_clk);
      scan_end = 1'b1;
      @(negedge core_clk);
      scan_end = 1'b0;
   endtask : scan

   // Chain of contact ops and block merges; X0 on, X1 off
   task automatic t_basic();
      lbu_op_t    ops [10] = '{OP_LOAD_OPEN, OP_SERIES_CLOSED, OP_SERIES_OPEN, OP_PAR_CLOSED, OP_INVERT,
                               OP_PAR_OPEN, OP_LOAD_CLOSED, OP_BLOCK_PAR, OP_LOAD_OPEN, OP_BLOCK_SERIES};
      logic [9:0] nm  = 10'b0111000010;
      logic [9:0] exv = 10'b1101010100;
      img.mem[0][0] = 1'b1;
      for (int i = 0; i < 10; i++) begin
         ex(ops[i], AREA_X, {15'h0000, nm[9-i]}, 0, 16'h0000);
         chk(result, exv[9-i]);
      end
      scan();
   endtask : t_basic

   // Output targets and the long two-word form
   task automatic t_out();
      ex(OP_LOAD_OPEN, AREA_X, 16'h0000, 0, 16'h0000);
      ex(OP_WRITE, AREA_Y, 16'h0002, 0, 16'h0000);
      chk(img.mem[1][2], 1'b1);
      ex(OP_WRITE, AREA_X, 16'h0005, 0, 16'h0000);
      chk(img.mem[0][5], 1'b0);
      chk(err_cnt[15:0], 16'h0001);
      ex(OP_LOAD_OPEN, AREA_X, 16'h0500, 1, 16'h0001);
      chk(result, 1'b0);
      scan();
   endtask : t_out

   // Four scans of X2 = 0,1,1,0 through edge loads, pulse and toggle
   task automatic t_edge();
      logic [3:0] xv = 4'b0110;
      logic [3:0] rv = 4'b0100;
      logic [3:0] tv = 4'b0111;
      logic [3:0] fv = 4'b0001;
      logic [3:0] pv = 4'b0101;
      logic [3:0] qv = 4'b0010;
      for (int s = 0; s < 4; s++) begin
         img.mem[0][2] = xv[3-s];
         ex(OP_RISE_LOAD, AREA_X, 16'h0002, 1, 16'h0001);
         chk(result, rv[3-s]);
         ex(OP_RISE_PULSE, AREA_P, 16'h0000, 1, 16'h0002);
         chk(img.mem[6][0], rv[3-s]);
         ex(OP_TOGGLE, AREA_Y, 16'h0004, 2, 16'h0003);
         chk(img.mem[1][4], tv[3-s]);
         ex(OP_FALL_LOAD, AREA_X, 16'h0002, 1, 16'h0004);
         chk(result, fv[3-s]);
         // Edge OR, trailing pulse and trailing series on their own slots
         ex(OP_RISE_PAR, AREA_X, 16'h0002, 1, 16'h0005);
         chk(result, pv[3-s]);
         ex(OP_FALL_PULSE, AREA_P, 16'h0001, 1, 16'h0007);
         chk(img.mem[6][1], qv[3-s]);
         ex(OP_FALL_SERIES, AREA_X, 16'h0002, 1, 16'h0006);
         chk(result, fv[3-s]);
         scan();
      end
   endtask : t_edge

   // Reset for 8 cycles, then the scenarios
   initial begin
      sys_rst = 1'b1;
      instr_valid = 1'b0;
      instr_word = 32'h00000000;
      scan_end = 1'b0;
      repeat (8) @(negedge core_clk);
      sys_rst = 1'b0;
      t_basic();
      t_out();
      t_edge();
      end_of_test();
   end
endmodule : ladder_boolean_unit_tb_top

/* File: sim/lbu_img_model.sv */
// Relay image model: one bit per area and low relay number
// Assumes lbu_top requests on core_clk, reads answered next cycle
`timescale 1ns/10ps
module lbu_img_model (
   input  wire logic                       core_clk,
   input  wire logic                       img_rd_req,
   input  wire lbu_pkg::lbu_area_t         img_area,
   input  wire logic [lbu_pkg::NUM_W-1:0]  img_addr,
   output logic                            img_rd_data,
   input  wire logic                       img_wr_en,
   input  wire logic                       img_wr_data
);
   import lbu_pkg::*;
   logic mem [0:7][0:15];
   logic ans_ff;
   logic bit_ff;
   logic junk_ff;
   // Clear image so reads start from a known state
   initial begin
      foreach (mem[i, j]) mem[i][j] = 1'b0;
      ans_ff = 1'b0;
      bit_ff = 1'b0;
      junk_ff = 1'b0;
   end
   // All eight areas readable; writes land at the pulse edge
   always @(posedge core_clk) begin
      ans_ff <= img_rd_req;
      bit_ff <= mem[img_area][img_addr[3:0]];
      junk_ff <= ~junk_ff;
      if (img_wr_en) mem[img_area][img_addr[3:0]] <= img_wr_data;
   end
   // Toggling junk outside the answer cycle, so a late sample shows
   assign img_rd_data = ans_ff ? bit_ff : junk_ff;
endmodule : lbu_img_model
